// ===== inc/cts_defines.vh
// Constants for the CAN transceiver supply control block.
`ifndef CTS_DEFINES_VH
`define CTS_DEFINES_VH

// ****************************************************************
// System mode codes
// ****************************************************************
`define CTS_MODE_STANDBY 2'h0
`define CTS_MODE_SLEEP 2'h1
`define CTS_MODE_NORM_V2OFF 2'h2
`define CTS_MODE_NORM 2'h3

// ****************************************************************
// Transceiver modes
// ****************************************************************
`define CTS_CAN_OFF 2'h0
`define CTS_CAN_LOWPWR 2'h1
`define CTS_CAN_ACTIVE 2'h2

// ****************************************************************
// Flag bit positions
// ****************************************************************
`define CTS_FLAG_POWER_ON 0
`define CTS_FLAG_MAIN_LOW 1
`define CTS_FLAG_CAN_LOW 2
`define CTS_FLAG_CAN_WAKE 3
`define CTS_FLAG_W 4
`define CTS_FLAGS_RESET 4'h1

// ****************************************************************
// Timing in microseconds and cycle counts at 50 MHz
// ****************************************************************
`define CTS_CLK_MHZ 50
`define CTS_T_DOM_TO_US 2500
`define CTS_T_WAKE_TO_US 1000
`define CTS_T_WAKE_MIN_US 1
`define CTS_DOM_TO_CYC (`CTS_T_DOM_TO_US * `CTS_CLK_MHZ)
`define CTS_WAKE_TO_CYC (`CTS_T_WAKE_TO_US * `CTS_CLK_MHZ)
`define CTS_WAKE_MIN_CYC (`CTS_T_WAKE_MIN_US * `CTS_CLK_MHZ)

`endif

// ===== core/cts_sync.v
// Two-stage synchroniser for one level signal.
`timescale 1ns/1ps
module cts_sync #(
    parameter RESET_VAL = 1'b1
) (
    // Clock and reset
    clk,
    reset,
    // Data
    d,
    q
);
    input wire clk;
    input wire reset;
    input wire d;
    output reg q;

    reg meta_r;

    // The first stage feeds only the second stage.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ===== core/cts_wake_filter.v
// CAN bus wake-up pattern filter.
`timescale 1ns/1ps
`include "cts_defines.vh"
module cts_wake_filter #(
    parameter WAKE_TO_CYC = `CTS_WAKE_TO_CYC,
    parameter MIN_CYC = `CTS_WAKE_MIN_CYC
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Control
    input wire enable,
    input wire bus_dom,
    // Result
    output reg wake_pulse
);
    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    localparam ST_REC1 = 3'h0;
    localparam ST_DOM1 = 3'h1;
    localparam ST_REC2 = 3'h2;
    localparam ST_DOM2 = 3'h3;
    localparam ST_DONE = 3'h4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [31:0] phase_r;
    reg [31:0] win_r;

    wire want_dom = (state_r == ST_DOM1) || (state_r == ST_DOM2);
    wire phase_ok = (phase_r >= MIN_CYC - 1);
    wire win_out = (state_r != ST_REC1) && (win_r >= WAKE_TO_CYC - 1);

    // A phase is accepted once it has lasted its minimum; shorter opposite pulses
    // only restart the phase counter, so extra pulses are tolerated.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_REC1, ST_DOM1, ST_REC2: begin
                if ((bus_dom == want_dom) && phase_ok) begin
                    state_nxt = state_r + 3'h1;
                end
            end
            ST_DOM2: begin
                if (bus_dom && phase_ok) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: state_nxt = ST_REC1;
            default: state_nxt = ST_REC1;
        endcase
    end

    // Counters in oscillator cycles; the window runs from the first dominant phase.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_REC1;
            phase_r <= 32'h0;
            win_r <= 32'h0;
            wake_pulse <= 1'b0;
        end else if (!enable || win_out) begin
            state_r <= ST_REC1;
            phase_r <= 32'h0;
            win_r <= 32'h0;
            wake_pulse <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wake_pulse <= (state_nxt == ST_DONE);
            if (state_nxt != state_r || bus_dom != want_dom) begin
                phase_r <= 32'h0;
            end else begin
                phase_r <= phase_r + 32'h1;
            end
            win_r <= (state_r == ST_REC1) ? 32'h0 : win_r + 32'h1;
        end
    end
endmodule

// ===== core/cts_supply_can.v
// Supply section and CAN transceiver control for the basis chip.
`timescale 1ns/1ps
`include "cts_defines.vh"
module cts_supply_can #(
    parameter DOM_TO_CYC = `CTS_DOM_TO_CYC,
    parameter WAKE_TO_CYC = `CTS_WAKE_TO_CYC,
    parameter WAKE_MIN_CYC = `CTS_WAKE_MIN_CYC
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Battery comparators
    input wire bat_below_poff,
    input wire bat_above_pon,
    // Main regulator comparators and controls
    input wire main_below_90,
    input wire main_below_70,
    input wire reset_threshold_select,
    input wire dissipation_split_select,
    // CAN supply comparator
    input wire can_supply_below_90,
    // Mode and standby control
    input wire [1:0] system_mode_field,
    input wire can_standby_control,
    // Flag clear, one bit per flag, write 1 to clear
    input wire [3:0] flag_clear,
    // Protocol controller and bus side
    input wire can_transmit_in,
    input wire bus_dominant,
    input wire wake_comp_dom,
    // Status and flags
    output reg [3:0] flags,
    output reg power_on_flag,
    output reg main_reg_low_warning_flag,
    output reg can_reg_low_warning_flag,
    output reg can_wake_flag,
    output reg main_reg_status,
    output reg can_reg_status,
    output reg interrupt_out_n,
    // Power and transceiver controls
    output reg device_off,
    output reg system_reset,
    output reg pass_threshold_low,
    output reg can_supply_regulator_en,
    output reg [1:0] can_mode,
    output reg can_receive_out,
    output reg can_tx_drive_dom,
    output reg split_en,
    output reg tx_timeout
);
    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    wire tx_s;
    wire wake_s;

    // Both asynchronous inputs cross before timers see them.
    cts_sync #(.RESET_VAL(1'b1)) u_sync_tx (
        .clk(clk),
        .reset(reset),
        .d(can_transmit_in),
        .q(tx_s)
    );

    cts_sync #(.RESET_VAL(1'b0)) u_sync_wake (
        .clk(clk),
        .reset(reset),
        .d(wake_comp_dom),
        .q(wake_s)
    );

    // ****************************************************************
    // Battery power state
    // ****************************************************************
    reg off_r;

    // Off is entered at once on low battery and left when battery recovers.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            off_r <= 1'b1;
        end else if (bat_below_poff) begin
            off_r <= 1'b1;
        end else if (off_r && bat_above_pon) begin
            off_r <= 1'b0;
        end
    end

    wire leave_off = off_r && !bat_below_poff && bat_above_pon;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    function is_normal;
        input [1:0] m;
        begin
            is_normal = (m == `CTS_MODE_NORM) || (m == `CTS_MODE_NORM_V2OFF);
        end
    endfunction

    wire normal = is_normal(system_mode_field) && !off_r;
    wire can_supply_ok = !can_supply_below_90;
    reg [1:0] mode_nxt;

    // Active needs Normal, standby bit clear and a good supply pin, whichever
    // source feeds it; outside battery Off the standby bit alone selects Lowpower.
    always @* begin
        if (off_r) begin
            mode_nxt = `CTS_CAN_OFF;
        end else if (can_standby_control) begin
            mode_nxt = `CTS_CAN_LOWPWR;
        end else if (normal && can_supply_ok) begin
            mode_nxt = `CTS_CAN_ACTIVE;
        end else begin
            mode_nxt = `CTS_CAN_OFF;
        end
    end

    // ****************************************************************
    // Dominant timeout
    // ****************************************************************
    reg [31:0] dom_cnt_r;
    reg timeout_r;

    // Counted in clock cycles; a high level clears both the count and the lockout,
    // which bounds the lowest usable bit rate.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dom_cnt_r <= 32'h0;
            timeout_r <= 1'b0;
        end else if (tx_s) begin
            dom_cnt_r <= 32'h0;
            timeout_r <= 1'b0;
        end else if (dom_cnt_r >= DOM_TO_CYC - 1) begin
            timeout_r <= 1'b1;
        end else begin
            dom_cnt_r <= dom_cnt_r + 32'h1;
        end
    end

    // ****************************************************************
    // Wake filter
    // ****************************************************************
    wire wake_pulse;

    // Only the Lowpower transceiver listens for remote wake-up.
    cts_wake_filter #(
        .WAKE_TO_CYC(WAKE_TO_CYC),
        .MIN_CYC(WAKE_MIN_CYC)
    ) u_wake (
        .clk(clk),
        .reset(reset),
        .enable(can_mode == `CTS_CAN_LOWPWR),
        .bus_dom(wake_s),
        .wake_pulse(wake_pulse)
    );

    // ****************************************************************
    // Sticky flags
    // ****************************************************************
    reg [3:0] set_v;
    reg [3:0] flags_nxt;
    reg main_low_d_r;
    reg can_low_d_r;

    // Warnings set on the falling crossing; a set in the same cycle as a clear wins,
    // so no event is lost.
    always @* begin
        set_v = 4'h0;
        set_v[`CTS_FLAG_POWER_ON] = leave_off;
        set_v[`CTS_FLAG_MAIN_LOW] = main_below_90 && !main_low_d_r && !off_r;
        set_v[`CTS_FLAG_CAN_LOW] = can_supply_below_90 && !can_low_d_r && !off_r;
        set_v[`CTS_FLAG_CAN_WAKE] = wake_pulse;
        flags_nxt = (flags & ~flag_clear) | set_v;
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Every output here is a flip-flop; Off mode holds the status, reset, CAN regulator enable, transceiver mode, receive, drive and split outputs quiet.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            flags <= `CTS_FLAGS_RESET;
            main_low_d_r <= 1'b0;
            can_low_d_r <= 1'b0;
            main_reg_status <= 1'b0;
            can_reg_status <= 1'b1;
            interrupt_out_n <= 1'b1;
            device_off <= 1'b1;
            system_reset <= 1'b1;
            pass_threshold_low <= 1'b0;
            can_supply_regulator_en <= 1'b0;
            can_mode <= `CTS_CAN_OFF;
            can_receive_out <= 1'b1;
            can_tx_drive_dom <= 1'b0;
            split_en <= 1'b0;
            tx_timeout <= 1'b0;
        end else begin
            flags <= flags_nxt;
            main_low_d_r <= main_below_90;
            can_low_d_r <= can_supply_below_90;
            device_off <= off_r;
            // Status shows the live regulator condition.
            main_reg_status <= !main_below_90 && !off_r;
            // Real CAN supply state only in Normal mode.
            can_reg_status <= normal ? can_supply_ok : 1'b1;
            // Interrupt pin low while any flag pends.
            interrupt_out_n <= ~(|flags_nxt);
            // Reset level chosen by the threshold bit.
            system_reset <= off_r ||
                (reset_threshold_select ? main_below_70 : main_below_90);
            // 1 selects the 50 mA take-over point, 0 the 85 mA one.
            pass_threshold_low <= dissipation_split_select;
            // Mode code 10 switches the CAN regulator off.
            can_supply_regulator_en <= !off_r &&
                (system_mode_field != `CTS_MODE_NORM_V2OFF);
            can_mode <= mode_nxt;
            // Receive and transmit paths work only in Active.
            can_receive_out <= (mode_nxt == `CTS_CAN_ACTIVE) ? !bus_dominant : 1'b1;
            can_tx_drive_dom <= (mode_nxt == `CTS_CAN_ACTIVE) && !tx_s && !timeout_r;
            // Split pin floats unless Active.
            split_en <= (mode_nxt == `CTS_CAN_ACTIVE);
            tx_timeout <= timeout_r;
        end
    end

    // Individual flag views for the status side.
    always @* begin
        power_on_flag = flags[`CTS_FLAG_POWER_ON];
        main_reg_low_warning_flag = flags[`CTS_FLAG_MAIN_LOW];
        can_reg_low_warning_flag = flags[`CTS_FLAG_CAN_LOW];
        can_wake_flag = flags[`CTS_FLAG_CAN_WAKE];
    end
endmodule

// ===== tb/cts_supply_can_chk.sv
// Assertion checker for the supply and CAN control block.
`timescale 1ns/1ps
module cts_supply_can_chk #(
    parameter DOM_TO_CYC = 50
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Inputs watched
    input wire bat_below_poff,
    input wire [1:0] system_mode_field,
    input wire can_transmit_in,
    // Outputs watched
    input wire [3:0] flags,
    input wire interrupt_out_n,
    input wire can_reg_status,
    input wire device_off,
    input wire can_supply_regulator_en,
    input wire [1:0] can_mode,
    input wire can_receive_out,
    input wire can_tx_drive_dom,
    input wire split_en
);
    reg [15:0] low_r;

    // Counts low samples of the transmit input; saturates so it never wraps.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            low_r <= 16'h0;
        end else if (can_transmit_in) begin
            low_r <= 16'h0;
        end else if (low_r != 16'hffff) begin
            low_r <= low_r + 16'h1;
        end
    end

    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_tx_idle; can_transmit_in [*6]; endsequence
    sequence s_not_act; (can_mode != 2'h2) [*2]; endsequence
    sequence s_on; (!device_off) [*2]; endsequence
    property p_split; split_en == (can_mode == 2'h2); endproperty
    property p_v2off; system_mode_field == 2'h2 |=> !can_supply_regulator_en; endproperty
    property p_canst; system_mode_field[1] == 1'b0 |=> can_reg_status; endproperty
    property p_irq; s_on |-> interrupt_out_n == !(|flags); endproperty
    property p_rx; s_not_act |-> can_receive_out; endproperty
    property p_txidle; s_tx_idle |-> !can_tx_drive_dom; endproperty
    property p_txto; low_r > DOM_TO_CYC + 6 |-> !can_tx_drive_dom; endproperty
    property p_off; bat_below_poff [*4] |-> device_off; endproperty
    a_split: assert property (p_split)
        else $error("split enable outside active mode");
    a_v2off: assert property (p_v2off)
        else $error("CAN regulator on in mode 10");
    a_canst: assert property (p_canst)
        else $error("CAN regulator status not 1 outside Normal");
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with flags");
    a_rx: assert property (p_rx)
        else $error("receive output not recessive outside active");
    a_txidle: assert property (p_txidle)
        else $error("bus driven while transmit input high");
    a_txto: assert property (p_txto)
        else $error("dominant drive past the timeout");
    a_off: assert property (p_off)
        else $error("device not off on battery loss");
endmodule

bind cts_supply_can cts_supply_can_chk #(.DOM_TO_CYC(DOM_TO_CYC)) u_chk (
    .clk(clk), .reset(reset), .bat_below_poff(bat_below_poff),
    .system_mode_field(system_mode_field), .can_transmit_in(can_transmit_in),
    .flags(flags), .interrupt_out_n(interrupt_out_n), .can_reg_status(can_reg_status),
    .device_off(device_off), .can_supply_regulator_en(can_supply_regulator_en),
    .can_mode(can_mode), .can_receive_out(can_receive_out),
    .can_tx_drive_dom(can_tx_drive_dom), .split_en(split_en)
);

// ===== tb/cts_can_partner.sv
// Behavioural protocol controller and CAN bus partner.
`timescale 1ns/1ps
module cts_can_partner (
    // Clock
    input wire clk,
    // Transceiver side
    input wire can_tx_drive_dom,
    output reg can_transmit_in,
    output wire bus_dominant,
    output wire wake_comp_dom
);
    reg remote_dom_r;

    // Wired bus: any node driving dominant wins; idle is recessive.
    assign bus_dominant = can_tx_drive_dom | remote_dom_r;
    assign wake_comp_dom = bus_dominant;

    // Transmit input rests high, as its pull-up would hold it.
    initial begin
        can_transmit_in = 1'b1;
        remote_dom_r = 1'b0;
    end

    // Dominant bit of n cycles; the timeout test holds it past the timeout.
    task tx_low(input integer n);
        begin
            can_transmit_in <= 1'b0;
            repeat (n) @(posedge clk);
            can_transmit_in <= 1'b1;
        end
    endtask

    // Remote node sends k alternating phases of n cycles, recessive first.
    task wake_seq(input integer n, input integer k);
        integer i;
        begin
            for (i = 0; i < k; i = i + 1) begin
                remote_dom_r <= i[0];
                repeat (n) @(posedge clk);
            end
            remote_dom_r <= 1'b0;
        end
    endtask
endmodule

// ===== tb/tb_cts_supply_can.sv
// Self-checking testbench for the supply and CAN control block.
`timescale 1ns/1ps
module tb_cts_supply_can;
    localparam f_fl = 0, f_md = 4, f_rx = 6, f_td = 7, f_sp = 8, f_re = 9, f_cs = 10;
    localparam f_ms = 11, f_iq = 12, f_of = 13, f_sr = 14, f_pt = 15, f_to = 16;
    localparam f_po = 17, f_mw = 18, f_cw = 19, f_ww = 20;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg bat_below_poff = 1'b0;
    reg bat_above_pon = 1'b0;
    reg main_below_90 = 1'b0;
    reg main_below_70 = 1'b0;
    reg reset_threshold_select = 1'b0;
    reg dissipation_split_select = 1'b0;
    reg can_supply_below_90 = 1'b0;
    reg [1:0] system_mode_field = 2'h0;
    reg can_standby_control = 1'b0;
    reg [3:0] flag_clear = 4'h0;
    wire can_transmit_in, bus_dominant, wake_comp_dom, main_reg_status, can_reg_status;
    wire interrupt_out_n, device_off, system_reset, pass_threshold_low, tx_timeout;
    wire can_supply_regulator_en, can_receive_out, can_tx_drive_dom, split_en;
    wire [3:0] flags;
    wire [1:0] can_mode;
    wire power_on_flag, main_reg_low_warning_flag, can_reg_low_warning_flag, can_wake_flag;
    // The single flag views sit above the packed status so each one is checked too.
    wire [20:0] ov = {can_wake_flag, can_reg_low_warning_flag, main_reg_low_warning_flag,
        power_on_flag, tx_timeout, pass_threshold_low, system_reset, device_off,
        interrupt_out_n, main_reg_status, can_reg_status, can_supply_regulator_en,
        split_en, can_tx_drive_dom, can_receive_out, can_mode, flags};
    logic [11:0] exp_q[$];
    reg [11:0] e;
    reg [20:0] got;
    reg [31:0] r;
    integer err_count = 0, checks = 0, seed = 32'hdc65, cyc = 0, i;

    // Clock of 20 ns.
    always #10 clk = ~clk;

    cts_supply_can #(.DOM_TO_CYC(50), .WAKE_TO_CYC(200), .WAKE_MIN_CYC(4)) dut (
        .clk(clk), .reset(reset), .bat_below_poff(bat_below_poff),
        .bat_above_pon(bat_above_pon), .main_below_90(main_below_90),
        .main_below_70(main_below_70), .reset_threshold_select(reset_threshold_select),
        .dissipation_split_select(dissipation_split_select),
        .can_supply_below_90(can_supply_below_90), .system_mode_field(system_mode_field),
        .can_standby_control(can_standby_control), .flag_clear(flag_clear),
        .can_transmit_in(can_transmit_in), .bus_dominant(bus_dominant),
        .wake_comp_dom(wake_comp_dom), .flags(flags), .power_on_flag(power_on_flag),
        .main_reg_low_warning_flag(main_reg_low_warning_flag),
        .can_reg_low_warning_flag(can_reg_low_warning_flag), .can_wake_flag(can_wake_flag),
        .main_reg_status(main_reg_status), .can_reg_status(can_reg_status),
        .interrupt_out_n(interrupt_out_n), .device_off(device_off),
        .system_reset(system_reset), .pass_threshold_low(pass_threshold_low),
        .can_supply_regulator_en(can_supply_regulator_en), .can_mode(can_mode),
        .can_receive_out(can_receive_out), .can_tx_drive_dom(can_tx_drive_dom),
        .split_en(split_en), .tx_timeout(tx_timeout)
    );

    cts_can_partner pm (
        .clk(clk), .can_tx_drive_dom(can_tx_drive_dom), .can_transmit_in(can_transmit_in),
        .bus_dominant(bus_dominant), .wake_comp_dom(wake_comp_dom)
    );

    // ********
    // Helpers
    // ********
    task ck(input integer n);
        repeat (n) @(posedge clk);
    endtask

    // Notes a field at position p, w bits wide, expected to read v.
    task note(input [4:0] p, input [2:0] w, input [3:0] v);
        exp_q.push_back({p, w, v});
    endtask

    task clr(input [3:0] m);
        begin
            flag_clear <= m;
            ck(1);
            flag_clear <= 4'h0;
            ck(2);
        end
    endtask

    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks, err_count);
            if (err_count == 0 && checks > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask

    // Compares notes at the falling edge, when outputs have settled.
    always @(negedge clk) begin
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            got = (ov >> e[11:7]) & ((21'h1 << e[6:4]) - 21'h1);
            checks = checks + 1;
            if (got !== {17'h0, e[3:0]}) begin
                $display("BAD %0t: field %0d got %h exp %h", $time, e[11:7], got, e[3:0]);
                err_count = err_count + 1;
            end
        end
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            $display("BAD %0t: run timed out", $time);
            test_done;
        end
    end

    // ********
    // Scenarios
    // ********
    initial begin
        ck(4);
        reset <= 1'b0;
        ck(3);
        note(f_of, 1, 4'h1);
        bat_above_pon <= 1'b1;
        ck(3);
        note(f_of, 1, 4'h0);
        note(f_fl, 1, 4'h1);
        note(f_po, 1, 4'h1);
        note(f_iq, 1, 4'h0);
        clr(4'h1);
        note(f_fl, 4, 4'h0);
        note(f_iq, 1, 4'h1);
        bat_below_poff <= 1'b1;
        bat_above_pon <= 1'b0;
        ck(4);
        note(f_of, 1, 4'h1);
        bat_below_poff <= 1'b0;
        bat_above_pon <= 1'b1;
        ck(4);
        note(f_fl, 4, 4'h1);
        clr(4'h1);
        $display("test battery done");
        for (i = 0; i < 6; i = i + 1) begin
            r = $random(seed);
            dissipation_split_select <= r[0];
            ck(2);
            note(f_pt, 1, {3'h0, dissipation_split_select});
        end
        // Both reset thresholds; the warning fires at 90 percent either way.
        for (i = 0; i < 2; i = i + 1) begin
            reset_threshold_select <= i[0];
            main_below_90 <= 1'b1;
            ck(3);
            note(f_sr, 1, {3'h0, ~i[0]});
            note(f_fl, 4, 4'h2);
            note(f_mw, 1, 4'h1);
            main_below_70 <= 1'b1;
            ck(3);
            note(f_sr, 1, 4'h1);
            note(f_ms, 1, 4'h0);
            main_below_90 <= 1'b0;
            main_below_70 <= 1'b0;
            ck(3);
            note(f_ms, 1, 4'h1);
            clr(4'h2);
        end
        $display("test main regulator done");
        // Every mode code with the standby bit low and high.
        for (i = 0; i < 8; i = i + 1) begin
            system_mode_field <= i[1:0];
            can_standby_control <= i[2];
            ck(3);
            note(f_md, 2, i[2] ? 4'h1 : (i[1] ? 4'h2 : 4'h0));
            note(f_sp, 1, {3'h0, ~i[2] & i[1]});
            note(f_re, 1, {3'h0, i[1:0] != 2'h2});
            note(f_cs, 1, 4'h1);
        end
        system_mode_field <= 2'h3;
        can_standby_control <= 1'b0;
        can_supply_below_90 <= 1'b1;
        ck(3);
        note(f_cs, 1, 4'h0);
        note(f_fl, 4, 4'h4);
        note(f_cw, 1, 4'h1);
        system_mode_field <= 2'h0;
        ck(3);
        note(f_cs, 1, 4'h1);
        can_supply_below_90 <= 1'b0;
        system_mode_field <= 2'h3;
        clr(4'h4);
        $display("test modes done");
        fork
            pm.tx_low(10);
            begin ck(7); note(f_td, 1, 4'h1); note(f_rx, 1, 4'h0); end
        join
        ck(6);
        note(f_td, 1, 4'h0);
        note(f_rx, 1, 4'h1);
        fork
            pm.tx_low(70);
            begin ck(62); note(f_to, 1, 4'h1); note(f_td, 1, 4'h0); end
        join
        ck(6);
        note(f_to, 1, 4'h0);
        fork
            pm.tx_low(20);
            begin ck(8); note(f_td, 1, 4'h1); end
        join
        ck(6);
        $display("test transmit done");
        system_mode_field <= 2'h0;
        can_standby_control <= 1'b1;
        ck(3);
        pm.wake_seq(2, 9);
        ck(6);
        note(f_fl, 4, 4'h0);
        pm.wake_seq(8, 5);
        ck(6);
        note(f_fl, 4, 4'h8);
        note(f_ww, 1, 4'h1);
        note(f_iq, 1, 4'h0);
        clr(4'h8);
        note(f_fl, 4, 4'h0);
        ck(2);
        $display("test wake done");
        test_done;
    end
endmodule
